// ---- logic/ecm_cam_block.sv ----
`timescale 1ns/1ps
`include "ecm_defines.svh"
module ecm_opt_reg #(
  parameter int W = 1,
  parameter bit EN = 1'b0
) (
  // Clock and clear
  input wire logic clock_i,
  input wire logic rst_i,
  // Path
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // Register inserted or bypassed per path
  if (EN) begin : g_reg
    logic [W-1:0] q_r;
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        q_r <= '0; // [RULE_01]
      end else begin
        q_r <= d_i;
      end
    end
    assign q_o = q_r;
  end else begin : g_thru
    assign q_o = d_i;
  end
endmodule

module ecm_cam_block #(
  parameter int WORDS = `ECM_WORDS,
  parameter int WIDTH = `ECM_WIDTH,
  parameter bit REG_WDATA = 1'b0,
  parameter bit REG_RDATA = 1'b0,
  parameter bit REG_RADDR = 1'b0,
  parameter bit REG_WADDR = 1'b0,
  parameter bit REG_WE = 1'b0,
  parameter bit REG_RE = 1'b0,
  parameter bit ROM_MODE = 1'b0,
  parameter logic [`ECM_WORDS*`ECM_WIDTH-1:0] PRELOAD_DATA = '0,
  parameter logic [`ECM_WORDS*`ECM_WIDTH-1:0] PRELOAD_CARE = '1,
  parameter logic [`ECM_WORDS-1:0] PRELOAD_VALID = '0
) (
  // Clock and asynchronous clear
  input wire logic clock_i,
  input wire logic rst_i,
  // Link to user logic
  ecm_if.dev link
);
  import ecm_pkg::*;

  // Geometry is fixed by the array structure
  if (WORDS != `ECM_WORDS || WIDTH != `ECM_WIDTH) begin : g_chk // [RULE_06]
    $error("ecm_cam_block: geometry must be 32 words of 32 bits");
  end

  localparam int HA = `ECM_HALF_ABITS;
  localparam int LN = `ECM_LINES;

  // Optional input-side registers, one per path
  wire logic [4*WIDTH-1:0] wdata_q;
  wire logic [`ECM_ABITS-1:0] waddr_q;
  wire logic [WIDTH+2*HA-1:0] raddr_q;
  wire logic [2:0] we_q;
  wire logic [2:0] re_q;
  ecm_opt_reg #(.W(4*WIDTH), .EN(REG_WDATA)) u_wdata (
    .clock_i(clock_i), .rst_i(rst_i), .d_i({link.wr_data, link.wr_care, link.ram_wdata}), .q_o(wdata_q)
  ); // [RULE_19]
  ecm_opt_reg #(.W(`ECM_ABITS), .EN(REG_WADDR)) u_waddr (
    .clock_i(clock_i), .rst_i(rst_i), .d_i(link.wr_addr), .q_o(waddr_q)
  ); // [RULE_19]
  ecm_opt_reg #(.W(WIDTH+2*HA), .EN(REG_RADDR)) u_raddr (
    .clock_i(clock_i), .rst_i(rst_i), .d_i({link.srch_data, link.ram_addr}), .q_o(raddr_q)
  ); // [RULE_19]
  ecm_opt_reg #(.W(3), .EN(REG_WE)) u_we (
    .clock_i(clock_i), .rst_i(rst_i), .d_i({link.wr_en, link.ram_we}), .q_o(we_q)
  ); // [RULE_19]
  ecm_opt_reg #(.W(3), .EN(REG_RE)) u_re (
    .clock_i(clock_i), .rst_i(rst_i), .d_i({link.srch_en, link.read_enable_strobe}), .q_o(re_q)
  ); // [RULE_19]

  // Path unpacking
  wire logic [WIDTH-1:0] wr_data_q = wdata_q[4*WIDTH-1 -: WIDTH];
  wire logic [WIDTH-1:0] wr_care_q = wdata_q[3*WIDTH-1 -: WIDTH];
  wire logic [1:0][WIDTH-1:0] ram_wdata_q = wdata_q[2*WIDTH-1:0];
  wire logic [WIDTH-1:0] key_q = raddr_q[WIDTH+2*HA-1 -: WIDTH];
  wire logic [1:0][HA-1:0] ram_addr_q = raddr_q[2*HA-1:0];
  wire logic cam_sel = (link.func == ECM_FUNC_CAM);
  wire logic ram_sel = (link.func == ECM_FUNC_RAM);
  wire logic [1:0] ram_wr = we_q[1:0] & {2{ram_sel & ~ROM_MODE}}; // [RULE_21]
  wire logic [1:0] ram_rd = re_q[1:0] & {2{ram_sel}};

  // Storage: contents, care masks, occupied flags
  logic [WIDTH-1:0] data_r [WORDS];
  logic [WIDTH-1:0] care_r [WORDS];
  logic [WORDS-1:0] valid_r;

  // Write sequencer state
  ecm_wst_t wst_r;
  ecm_wst_t wst_nxt;
  logic [`ECM_ABITS-1:0] wa_r;
  logic [WIDTH-1:0] wd_r;
  logic [WIDTH-1:0] wc_r;
  wire logic wr_go = we_q[2] & (wst_r == ECM_W_IDLE) & cam_sel & ~ROM_MODE;
  wire logic has_dc = (wc_r != `ECM_CARE_ALL);
  wire logic commit = ((wst_r == ECM_W_TWO) & ~has_dc) | (wst_r == ECM_W_THREE);

  // Sequencer next state
  always_comb begin
    case (wst_r)
      ECM_W_IDLE: wst_nxt = wr_go ? ECM_W_ONE : ECM_W_IDLE;
      ECM_W_ONE: wst_nxt = ECM_W_TWO; // [RULE_13]
      ECM_W_TWO: wst_nxt = has_dc ? ECM_W_THREE : ECM_W_IDLE; // [RULE_18]
      default: wst_nxt = ECM_W_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wst_r <= ECM_W_IDLE; // [RULE_01]
      wa_r <= '0;
      wd_r <= '0;
      wc_r <= '0;
    end else begin
      wst_r <= wst_nxt;
      if (wr_go) begin
        wa_r <= waddr_q;
        wd_r <= wr_data_q;
        wc_r <= wr_care_q;
      end
    end
  end

  // Array: preload pattern at clear, CAM commits, RAM-half writes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < WORDS; k++) begin
        data_r[k] <= PRELOAD_DATA[k*WIDTH +: WIDTH]; // [RULE_17] [RULE_21]
        care_r[k] <= PRELOAD_CARE[k*WIDTH +: WIDTH];
      end
      valid_r <= PRELOAD_VALID;
    end else if (commit) begin
      data_r[wa_r] <= wd_r; // [RULE_17]
      care_r[wa_r] <= wc_r;
      valid_r[wa_r] <= 1'b1;
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (ram_wr[h]) begin
          data_r[{h[0], ram_addr_q[h]}] <= ram_wdata_q[h]; // [RULE_02]
          care_r[{h[0], ram_addr_q[h]}] <= `ECM_CARE_ALL;
          valid_r[{h[0], ram_addr_q[h]}] <= 1'b1;
        end
      end
    end
  end

  // Lowest set position
  function automatic logic [`ECM_ABITS-1:0] ecm_lowest(input logic [`ECM_WORDS-1:0] v);
    logic [`ECM_ABITS-1:0] r;
    r = '0;
    for (int k = `ECM_WORDS - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = k[`ECM_ABITS-1:0];
      end
    end
    return r;
  endfunction

  // Parallel compare of all words, masked bits ignored
  wire logic [WIDTH-1:0] cmp_mask = link.encoded ? `ECM_CARE_ALL : `ECM_CMP_UNENC; // [RULE_11]
  wire logic bank = key_q[`ECM_BANK_BIT];
  logic [WORDS-1:0] hit_w;
  logic [LN-1:0] bank_lines;
  for (genvar g = 0; g < WORDS; g++) begin : g_cmp
    assign hit_w[g] = valid_r[g] & ~|((key_q ^ data_r[g]) & care_r[g] & cmp_mask); // [RULE_03] [RULE_07]
  end
  for (genvar i = 0; i < LN; i++) begin : g_bank
    assign bank_lines[i] = bank ? hit_w[2*i+1] : hit_w[2*i]; // [RULE_12]
  end

  // Result selection per mode
  logic pend_r;
  wire logic is_multi = (link.mode == ECM_MODE_MULTI);
  wire logic is_fast = (link.mode == ECM_MODE_FAST);
  wire logic srch_ok = re_q[2] & cam_sel & ~pend_r;
  wire logic [WORDS-1:0] hit_lo = {{(WORDS-LN){1'b0}}, hit_w[LN-1:0]}; // [RULE_16]
  wire logic [LN-1:0] lines_nxt = (is_multi | is_fast) ? hit_w[LN-1:0] : bank_lines; // [RULE_10] [RULE_14]
  wire logic match_nxt = is_fast ? |hit_lo : |hit_w; // [RULE_04] [RULE_05]
  wire logic [`ECM_ABITS-1:0] addr_nxt = (~link.encoded | is_multi) ? '0 :
    ecm_lowest(is_fast ? hit_lo : hit_w); // [RULE_08] [RULE_09]

  // Output registers, same clock as input side in this build
  logic res_valid_r;
  logic res_phase_r;
  logic match_r;
  logic [`ECM_ABITS-1:0] addr_r;
  logic [LN-1:0] lines_r;
  logic [LN-1:0] hi_r;
  logic [1:0][WIDTH-1:0] rd_r;
  always_ff @(posedge clock_i or posedge rst_i) begin // [RULE_20]
    if (rst_i) begin
      res_valid_r <= 1'b0; // [RULE_01]
      res_phase_r <= 1'b0;
      match_r <= 1'b0;
      addr_r <= '0;
      lines_r <= '0;
      hi_r <= '0;
      pend_r <= 1'b0;
    end else begin
      res_valid_r <= srch_ok | pend_r; // [RULE_13]
      if (srch_ok) begin
        match_r <= match_nxt;
        addr_r <= addr_nxt;
        lines_r <= lines_nxt;
        res_phase_r <= is_multi ? 1'b0 : (bank & ~is_fast);
        hi_r <= hit_w[WORDS-1 -: LN];
        pend_r <= is_multi; // [RULE_14]
      end else if (pend_r) begin
        lines_r <= hi_r; // [RULE_14]
        res_phase_r <= 1'b1;
        pend_r <= 1'b0;
      end
    end
  end

  // RAM-half and lookup-table reads
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_r <= '0; // [RULE_01]
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (ram_rd[h]) begin
          rd_r[h] <= data_r[{h[0], ram_addr_q[h]}]; // [RULE_02] [RULE_21]
        end
      end
    end
  end
  ecm_opt_reg #(.W(2*WIDTH), .EN(REG_RDATA)) u_rdata (
    .clock_i(clock_i), .rst_i(rst_i), .d_i(rd_r), .q_o(link.ram_rdata)
  ); // [RULE_19]

  // Link outputs
  assign link.busy = (wst_r != ECM_W_IDLE); // [RULE_18]
  assign link.res_valid = res_valid_r;
  assign link.res_phase = res_phase_r;
  assign link.match = match_r;
  assign link.match_addr = addr_r;
  assign link.match_lines = lines_r;
endmodule

// ---- logic/ecm_defines.svh ----
`ifndef ECM_DEFINES_SVH
`define ECM_DEFINES_SVH
// Contract
// RULE_01 - Every block register clears asynchronously
// RULE_02 - Two independent single-port RAMs per block
// RULE_03 - Search compares all words, returns address
// RULE_04 - Match flag high when any word matches
// RULE_05 - Match flag low when nothing matches
// RULE_06 - Search array is 32 words of 32 bits
// RULE_07 - Don't-care stored bits never block matches
// RULE_08 - Three result modes, encoded or one-hot
// RULE_09 - Encoded result is matching location number
// RULE_10 - Unencoded result uses 16 one-hot lines
// RULE_11 - Unencoded compares 31 bits, one bank select
// RULE_12 - Bank one odd words, zero even words
// RULE_13 - Single-match: write two cycles, search one
// RULE_14 - Multiple-match reports 16 lines per cycle
// RULE_15 - User logic priority-encodes multiple-match lines
// RULE_16 - Fast multiple-match: one cycle, 16 words
// RULE_17 - Contents preloaded at configuration or written
// RULE_18 - Write two cycles, three with don't-cares
// RULE_19 - Optional registers on each data/control path
// RULE_20 - Input and output registers clocked separately (both on clock_i in this build)
// RULE_21 - Preloaded block works as read-only table

// Array geometry
`define ECM_WIDTH 32
`define ECM_WORDS 32
`define ECM_ABITS 5
`define ECM_LINES 16
`define ECM_LBITS 4
`define ECM_HALF_ABITS 4
`define ECM_BANK_BIT 31
// Compare masks
`define ECM_CARE_ALL 32'hFFFFFFFF
`define ECM_CMP_UNENC 32'h7FFFFFFF
// Write timing in cycles
`define ECM_CNT_BITS 3
`define ECM_WR_CYC 3'h2
`define ECM_WR_DC_CYC 3'h3
`define ECM_PIPE_MAX 3
`endif

// ---- logic/ecm_pkg.sv ----
package ecm_pkg;
  // Result modes
  typedef enum logic [2:0] {
    ECM_MODE_SINGLE = 3'h1,
    ECM_MODE_MULTI = 3'h2,
    ECM_MODE_FAST = 3'h4
  } ecm_mode_t;
  // Block function
  typedef enum logic [1:0] {
    ECM_FUNC_CAM = 2'h1,
    ECM_FUNC_RAM = 2'h2
  } ecm_func_t;
  // Device write sequencer
  typedef enum logic [3:0] {
    ECM_W_IDLE = 4'h1,
    ECM_W_ONE = 4'h2,
    ECM_W_TWO = 4'h4,
    ECM_W_THREE = 4'h8
  } ecm_wst_t;
  // User-side sequencer
  typedef enum logic [2:0] {
    ECM_H_IDLE = 3'h1,
    ECM_H_WRITE = 3'h2,
    ECM_H_SRCH = 3'h4
  } ecm_hst_t;
endpackage

// ---- logic/ecm_if.sv ----
`timescale 1ns/1ps
`include "ecm_defines.svh"
interface ecm_if;
  // Configuration
  ecm_pkg::ecm_func_t func;
  ecm_pkg::ecm_mode_t mode;
  logic encoded;
  // Search array write
  logic wr_en;
  logic [`ECM_ABITS-1:0] wr_addr;
  logic [`ECM_WIDTH-1:0] wr_data;
  logic [`ECM_WIDTH-1:0] wr_care;
  logic busy;
  // Search
  logic srch_en;
  logic [`ECM_WIDTH-1:0] srch_data;
  logic res_valid;
  logic res_phase;
  logic match;
  logic [`ECM_ABITS-1:0] match_addr;
  logic [`ECM_LINES-1:0] match_lines;
  // Two single-port RAM halves
  logic [1:0] ram_we;
  logic [1:0] read_enable_strobe;
  logic [1:0][`ECM_HALF_ABITS-1:0] ram_addr;
  logic [1:0][`ECM_WIDTH-1:0] ram_wdata;
  logic [1:0][`ECM_WIDTH-1:0] ram_rdata;

  modport dev (
    input func, mode, encoded, wr_en, wr_addr, wr_data, wr_care, srch_en, srch_data,
    input ram_we, read_enable_strobe, ram_addr, ram_wdata,
    output busy, res_valid, res_phase, match, match_addr, match_lines, ram_rdata
  );
  modport usr (
    output func, mode, encoded, wr_en, wr_addr, wr_data, wr_care, srch_en, srch_data,
    output ram_we, read_enable_strobe, ram_addr, ram_wdata,
    input busy, res_valid, res_phase, match, match_addr, match_lines, ram_rdata
  );
endinterface

// ---- logic/ecm_user_end.sv ----
`timescale 1ns/1ps
`include "ecm_defines.svh"
module ecm_user_end #(
  parameter int PIPE_LAT = 0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Configuration
  input wire ecm_pkg::ecm_func_t u_func_i,
  input wire ecm_pkg::ecm_mode_t u_mode_i,
  input wire logic u_encoded_i,
  // Write command
  input wire logic u_wr_i,
  input wire logic [`ECM_ABITS-1:0] u_waddr_i,
  input wire logic [`ECM_WIDTH-1:0] u_wdata_i,
  input wire logic [`ECM_WIDTH-1:0] u_wcare_i,
  // Search command
  input wire logic u_srch_i,
  input wire logic [`ECM_WIDTH-1:0] u_key_i,
  input wire logic u_bank_i,
  // RAM halves
  input wire logic [1:0] u_ram_we_i,
  input wire logic [1:0] u_ram_re_i,
  input wire logic [1:0][`ECM_HALF_ABITS-1:0] u_ram_addr_i,
  input wire logic [1:0][`ECM_WIDTH-1:0] u_ram_wdata_i,
  // Status and results
  output logic u_ready_o,
  output logic u_done_o,
  output logic u_hit_o,
  output logic [`ECM_ABITS-1:0] u_hit_addr_o,
  output logic [`ECM_LINES-1:0] u_lines_o,
  output logic [1:0][`ECM_WIDTH-1:0] u_ram_rdata_o,
  // Link to the block
  ecm_if.usr link
);
  import ecm_pkg::*;

  // Counter must hold write time plus path latency
  if (PIPE_LAT < 0 || PIPE_LAT > `ECM_PIPE_MAX) begin : g_chk
    $error("ecm_user_end: PIPE_LAT out of range");
  end

  ecm_hst_t hst_r;
  logic [`ECM_CNT_BITS-1:0] cnt_r;
  ecm_func_t func_r;
  ecm_mode_t mode_r;
  logic enc_r;
  logic wr_en_r;
  logic srch_en_r;
  logic [`ECM_ABITS-1:0] wa_r;
  logic [`ECM_WIDTH-1:0] wd_r;
  logic [`ECM_WIDTH-1:0] wc_r;
  logic [`ECM_WIDTH-1:0] key_r;
  logic [1:0] ram_we_r;
  logic [1:0] ram_re_r;
  logic [1:0][`ECM_HALF_ABITS-1:0] ram_addr_r;
  logic [1:0][`ECM_WIDTH-1:0] ram_wdata_r;
  logic found_r;
  logic done_r;
  logic hit_r;
  logic [`ECM_ABITS-1:0] hit_addr_r;
  logic [`ECM_LINES-1:0] lines_r;

  // Lowest active result line
  function automatic logic [`ECM_LBITS-1:0] ecm_low16(input logic [`ECM_LINES-1:0] v);
    logic [`ECM_LBITS-1:0] r;
    r = '0;
    for (int k = `ECM_LINES - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = k[`ECM_LBITS-1:0];
      end
    end
    return r;
  endfunction

  // Command shaping
  wire logic idle = (hst_r == ECM_H_IDLE);
  wire logic [`ECM_WIDTH-1:0] key_nxt = u_encoded_i ? u_key_i :
    {u_bank_i, u_key_i[`ECM_BANK_BIT-1:0]}; // [RULE_11]
  wire logic [`ECM_CNT_BITS-1:0] wcnt_nxt = ((u_wcare_i == `ECM_CARE_ALL) ? `ECM_WR_CYC : `ECM_WR_DC_CYC)
    + PIPE_LAT[`ECM_CNT_BITS-1:0]; // [RULE_18] [RULE_13]

  // Result decode, priority encoder for multiple-match
  wire logic [`ECM_LBITS-1:0] low = ecm_low16(link.match_lines);
  wire logic is_multi = (mode_r == ECM_MODE_MULTI);
  wire logic last = link.res_valid & (~is_multi | link.res_phase);
  wire logic any_now = is_multi ? |link.match_lines : link.match;
  wire logic [`ECM_ABITS-1:0] addr_nxt = is_multi ? {link.res_phase, low} : // [RULE_15]
    enc_r ? link.match_addr :
    (mode_r == ECM_MODE_FAST) ? {1'b0, low} : {low, link.res_phase};

  // Sequencer
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hst_r <= ECM_H_IDLE;
      cnt_r <= '0;
      func_r <= ECM_FUNC_CAM;
      mode_r <= ECM_MODE_SINGLE;
      enc_r <= 1'b1;
      wr_en_r <= 1'b0;
      srch_en_r <= 1'b0;
      wa_r <= '0;
      wd_r <= '0;
      wc_r <= '0;
      key_r <= '0;
      found_r <= 1'b0;
      done_r <= 1'b0;
      hit_r <= 1'b0;
      hit_addr_r <= '0;
      lines_r <= '0;
    end else begin
      wr_en_r <= 1'b0;
      srch_en_r <= 1'b0;
      done_r <= 1'b0;
      case (hst_r)
        ECM_H_IDLE: begin
          func_r <= u_func_i;
          mode_r <= u_mode_i;
          enc_r <= u_encoded_i;
          if (u_wr_i) begin
            wr_en_r <= 1'b1;
            wa_r <= u_waddr_i;
            wd_r <= u_wdata_i;
            wc_r <= u_wcare_i;
            cnt_r <= wcnt_nxt;
            hst_r <= ECM_H_WRITE;
          end else if (u_srch_i) begin
            srch_en_r <= 1'b1;
            key_r <= key_nxt;
            found_r <= 1'b0;
            hit_addr_r <= '0;
            hst_r <= ECM_H_SRCH;
          end
        end
        ECM_H_WRITE: begin
          if (cnt_r == '0) begin
            done_r <= 1'b1; // [RULE_18]
            hst_r <= ECM_H_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ECM_H_SRCH: begin
          if (link.res_valid) begin
            lines_r <= link.match_lines;
            if (~found_r & any_now) begin
              found_r <= 1'b1;
              hit_addr_r <= addr_nxt; // [RULE_15]
            end
            if (last) begin
              hit_r <= link.match;
              done_r <= 1'b1;
              hst_r <= ECM_H_IDLE;
            end
          end
        end
        default: hst_r <= ECM_H_IDLE;
      endcase
    end
  end

  // RAM halves forwarded through one register stage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ram_we_r <= '0;
      ram_re_r <= '0;
      ram_addr_r <= '0;
      ram_wdata_r <= '0;
    end else begin
      ram_we_r <= u_ram_we_i;
      ram_re_r <= u_ram_re_i;
      ram_addr_r <= u_ram_addr_i;
      ram_wdata_r <= u_ram_wdata_i;
    end
  end

  // Link drive
  assign link.func = func_r;
  assign link.mode = mode_r;
  assign link.encoded = enc_r;
  assign link.wr_en = wr_en_r;
  assign link.wr_addr = wa_r;
  assign link.wr_data = wd_r;
  assign link.wr_care = wc_r;
  assign link.srch_en = srch_en_r;
  assign link.srch_data = key_r;
  assign link.ram_we = ram_we_r;
  assign link.read_enable_strobe = ram_re_r;
  assign link.ram_addr = ram_addr_r;
  assign link.ram_wdata = ram_wdata_r;

  // User outputs
  assign u_ready_o = idle;
  assign u_done_o = done_r;
  assign u_hit_o = hit_r;
  assign u_hit_addr_o = hit_addr_r;
  assign u_lines_o = lines_r;
  assign u_ram_rdata_o = link.ram_rdata;
endmodule

// ---- testbench/ecm_cam_chk.sv ----
`timescale 1ns/1ps
`include "ecm_defines.svh"
module ecm_cam_chk (
  // Clock and clear
  input wire logic clock_i,
  input wire logic rst_i,
  // Link signals
  input wire ecm_pkg::ecm_func_t func,
  input wire ecm_pkg::ecm_mode_t mode,
  input wire logic encoded,
  input wire logic wr_en,
  input wire logic [`ECM_WIDTH-1:0] wr_care,
  input wire logic busy,
  input wire logic srch_en,
  input wire logic [`ECM_WIDTH-1:0] srch_data,
  input wire logic res_valid,
  input wire logic res_phase,
  input wire logic match,
  input wire logic [`ECM_ABITS-1:0] match_addr,
  input wire logic [`ECM_LINES-1:0] match_lines
);
  import ecm_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Requests actually taken by the block
  wire wr_take = wr_en && !busy && func == ECM_FUNC_CAM;
  wire sr_take = srch_en && func == ECM_FUNC_CAM;
  // Write occupancy and search answer timing
  a_wr_two_cyc: assert property (wr_take && wr_care == `ECM_CARE_ALL |=> busy [*2] ##1 !busy)
    else $error("plain write did not hold busy two cycles");
  a_wr_dc_cyc: assert property (wr_take && wr_care != `ECM_CARE_ALL |=> busy [*3] ##1 !busy)
    else $error("masked write did not hold busy three cycles");
  a_single_one: assert property (sr_take && mode == ECM_MODE_SINGLE |=> res_valid)
    else $error("single search answer late");
  a_multi_two: assert property (sr_take && mode == ECM_MODE_MULTI |=> res_valid && !res_phase ##1 res_valid && res_phase)
    else $error("multi search phases wrong");
  a_fast_one: assert property (sr_take && mode == ECM_MODE_FAST |=> res_valid && !res_phase)
    else $error("fast search answer wrong");
  // Result flags against result lines
  a_fast_flag: assert property (res_valid && mode == ECM_MODE_FAST |-> match == (|match_lines))
    else $error("fast match flag disagrees with lines");
  a_miss_quiet: assert property (res_valid && !match && mode == ECM_MODE_SINGLE |-> match_addr == 0 && match_lines == 0)
    else $error("miss left address or lines set");
  a_bank_phase: assert property (res_valid && mode == ECM_MODE_SINGLE && !encoded |-> res_phase == $past(srch_data[31]))
    else $error("bank select not reflected");
  a_res_cause: assert property (res_valid && mode != ECM_MODE_MULTI |-> $past(srch_en))
    else $error("result without a search");
  a_res_stand: assert property (!res_valid |-> $stable(match) && $stable(match_addr) && $stable(match_lines))
    else $error("result changed without a search");
  // Main scenarios
  c_dc_write: cover property (wr_take && wr_care != `ECM_CARE_ALL);
  c_multi_hit: cover property (res_valid && res_phase && mode == ECM_MODE_MULTI && match);
  c_unenc_hit: cover property (res_valid && !encoded && match);
endmodule

// ---- testbench/tb_ecm_cam_block.sv ----
`timescale 1ns/1ps
`include "ecm_defines.svh"
module tb_ecm_cam_block;
  import ecm_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  ecm_func_t u_func = ECM_FUNC_CAM;
  ecm_mode_t u_mode = ECM_MODE_SINGLE;
  logic u_enc = 1'b1;
  logic u_wr = 1'b0;
  logic u_srch = 1'b0;
  logic u_bank = 1'b0;
  logic [`ECM_ABITS-1:0] u_waddr = '0;
  logic [`ECM_WIDTH-1:0] u_wdata = '0;
  logic [`ECM_WIDTH-1:0] u_wcare = '1;
  logic [`ECM_WIDTH-1:0] u_key = '0;
  logic [1:0] r_we = '0;
  logic [1:0] r_re = '0;
  logic [1:0][`ECM_HALF_ABITS-1:0] r_addr = '0;
  logic [1:0][`ECM_WIDTH-1:0] r_wdata = '0;
  logic u_ready;
  logic u_done;
  logic u_hit;
  logic [`ECM_ABITS-1:0] u_hit_addr;
  logic [`ECM_LINES-1:0] u_lines;
  logic [1:0][`ECM_WIDTH-1:0] u_rdata;
  logic [31:0] m_data [32];
  logic [31:0] m_care [32];
  bit m_val [32];
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // Clock
  always #2 clock_i = ~clock_i;
  // Both ends and the checker
  ecm_if lnk ();
  ecm_cam_block i_ecm_cam_block (.clock_i(clock_i), .rst_i(rst_i), .link(lnk.dev));
  ecm_user_end i_ecm_user_end (.clock_i(clock_i), .rst_i(rst_i), .u_func_i(u_func), .u_mode_i(u_mode),
    .u_encoded_i(u_enc), .u_wr_i(u_wr), .u_waddr_i(u_waddr), .u_wdata_i(u_wdata), .u_wcare_i(u_wcare),
    .u_srch_i(u_srch), .u_key_i(u_key), .u_bank_i(u_bank), .u_ram_we_i(r_we), .u_ram_re_i(r_re),
    .u_ram_addr_i(r_addr), .u_ram_wdata_i(r_wdata), .u_ready_o(u_ready), .u_done_o(u_done), .u_hit_o(u_hit),
    .u_hit_addr_o(u_hit_addr), .u_lines_o(u_lines), .u_ram_rdata_o(u_rdata), .link(lnk.usr));
  ecm_cam_chk i_chk (.clock_i(clock_i), .rst_i(rst_i), .func(lnk.func), .mode(lnk.mode), .encoded(lnk.encoded),
    .wr_en(lnk.wr_en), .wr_care(lnk.wr_care), .busy(lnk.busy), .srch_en(lnk.srch_en), .srch_data(lnk.srch_data),
    .res_valid(lnk.res_valid), .res_phase(lnk.res_phase), .match(lnk.match), .match_addr(lnk.match_addr),
    .match_lines(lnk.match_lines));
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_lat(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Raise one command when idle, count cycles to done
  task automatic run_cmd(input bit is_wr, output int lat);
    for (int k = 0; k < 20 && u_ready !== 1'b1; k++) @(posedge clock_i);
    @(posedge clock_i);
    if (is_wr) u_wr <= 1'b1;
    else u_srch <= 1'b1;
    @(posedge clock_i);
    u_wr <= 1'b0;
    u_srch <= 1'b0;
    lat = 0;
    for (int k = 1; k <= 12 && lat == 0; k++) begin
      @(posedge clock_i);
      #1;
      if (u_done === 1'b1) lat = k;
    end
  endtask
  task automatic wr_word(input int a, input logic [31:0] d, input logic [31:0] c);
    int lat;
    @(posedge clock_i);
    u_waddr <= a[4:0];
    u_wdata <= d;
    u_wcare <= c;
    run_cmd(1'b1, lat);
    chk_lat("write latency", (c === '1) ? 3 : 4, lat);
    m_data[a] = d;
    m_care[a] = c;
    m_val[a] = 1'b1;
  endtask
  // Expected match vector
  function automatic logic [31:0] hits(input logic [31:0] key, input logic [31:0] mask);
    logic [31:0] h;
    h = '0;
    for (int w = 0; w < 32; w++) h[w] = m_val[w] && (((m_data[w] ^ key) & m_care[w] & mask) == 0);
    return h;
  endfunction
  function automatic logic [4:0] lowest(input logic [31:0] h);
    logic [4:0] r;
    r = '0;
    for (int w = 31; w >= 0; w--) if (h[w]) r = w[4:0];
    return r;
  endfunction
  task automatic search(input ecm_mode_t md, input logic enc, input logic [31:0] key, input logic bank);
    logic [31:0] h;
    logic [15:0] ln;
    logic [4:0] ea;
    int lat;
    @(posedge clock_i);
    u_mode <= md;
    u_enc <= enc;
    u_key <= key;
    u_bank <= bank;
    h = hits(key, enc ? `ECM_CARE_ALL : `ECM_CMP_UNENC);
    if (md == ECM_MODE_FAST) h = h & 32'h0000FFFF;
    ea = lowest(h);
    for (int i = 0; i < 16; i++) ln[i] = (md == ECM_MODE_SINGLE) ? h[2 * i + bank] : h[i + 16 * (md == ECM_MODE_MULTI)];
    if (md == ECM_MODE_SINGLE && !enc) ea = {lowest({16'h0000, ln}), bank};
    run_cmd(1'b0, lat);
    chk_lat("search latency", (md == ECM_MODE_MULTI) ? 3 : 2, lat);
    chk("hit", {31'h0, |h}, {31'h0, u_hit});
    if (!enc || md != ECM_MODE_SINGLE) chk("lines", {16'h0, ln}, {16'h0, u_lines});
    if (|ln || (enc && |h)) chk("hit address", {27'h0, ea}, {27'h0, u_hit_addr});
  endtask
  // Main sequence
  initial begin
    logic [31:0] key;
    int w;
    void'($urandom(32'h7C54EA82));
    for (int i = 0; i < 32; i++) m_val[i] = 1'b0;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk("ready after reset", 32'h1, {31'h0, u_ready});
    search(ECM_MODE_SINGLE, 1'b1, $urandom, 1'b0);
    $display("Test reset done");
    for (int a = 0; a < 32; a++) wr_word(a, $urandom, (a % 7 == 3) ? 32'hFFFF00FF : 32'hFFFFFFFF);
    wr_word(20, m_data[5], 32'hFFFFFFFF);
    wr_word(13, m_data[12], 32'h7FFFFFFF);
    $display("Test write done");
    // Every result mode, encoded and one-hot
    for (int m = 0; m < 3; m++) begin
      for (int e = 0; e < 2; e++) begin
        for (int t = 0; t < 7; t++) begin
          w = (t == 0) ? 5 : (t == 1) ? 12 : $urandom % 32;
          key = m_data[w] ^ ($urandom & ~m_care[w]);
          if (t == 6) key = $urandom;
          search(ecm_mode_t'(3'h1 << m), e[0], key, $urandom % 2);
        end
      end
    end
    $display("Test search done");
    // Two RAM halves written and read together
    @(posedge clock_i);
    u_func <= ECM_FUNC_RAM;
    repeat (2) @(posedge clock_i);
    r_we <= 2'h3;
    r_addr <= {4'($urandom), 4'($urandom)};
    r_wdata <= {32'($urandom), 32'($urandom)};
    @(posedge clock_i);
    r_we <= 2'h0;
    r_re <= 2'h3;
    @(posedge clock_i);
    r_re <= 2'h0;
    @(posedge clock_i);
    #1;
    chk("ram half 0", r_wdata[0], u_rdata[0]);
    chk("ram half 1", r_wdata[1], u_rdata[1]);
    $display("Test ram done");
    // Clear in mid-run reloads the empty preload
    @(posedge clock_i);
    u_func <= ECM_FUNC_CAM;
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    key = m_data[7];
    for (int i = 0; i < 32; i++) m_val[i] = 1'b0;
    search(ECM_MODE_SINGLE, 1'b1, key, 1'b0);
    $display("Test clear done");
    finish_test();
  end
endmodule
